// ---- adc_readout_slave.sv ----
// Two-wire bus slave with read-triggered successive approximation conversion sequencing.
// Notes on behaviour
// - a valid read address starts a new conversion unless one is still running.
// - launch at falling edge of acknowledge clock; runs while old result shifts out.
// - launch samples the selected channel and converts it to eight bits.
// - differential channels give a two's complement result.
// - each finished result is latched in the holding register until sent.
// - auto-increment advances the channel after each conversion completes.
// - first byte read is the result launched in the previous read.
// - after reset the holding register reads hexadecimal 80.
// - conversion sequencing runs on the oscillator clock, not the bus clock.
// - source select low drives the internal oscillator out; it runs in the wake window, during a conversion or with output enabled.
// - source select high releases the oscillator pin for an external clock.
// - idle bus is high; start is data falling while clock high.
// - stop is data rising while clock high.
// - one bit per clock pulse; data change during clock high is control.
// - as receiver the device acknowledges every byte on the ninth pulse.
// - acknowledger holds data low through the acknowledge clock high phase.
// - after a read byte without acknowledge the device releases data.
// - a write ends at stop or at the next start.
// - address is a fixed upper part plus three hardware pins.
// - second write byte is stored as the control setting.
// - missing channel selects highest; auto-increment then wraps to zero.
// - reset clears the control setting, disabling output; the oscillator then runs only in the wake window and during conversions.
`timescale 1ns/1ps
`default_nettype none
module adc_readout_slave
  import adc_slave_pkg::*;
(
  // Main clock and reset.
  input wire logic mclk,
  input wire logic srst,
  // Oscillator clock as seen back from the oscillator pin.
  input wire logic osc_clk,
  // Two-wire bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Hardware address and oscillator straps.
  input wire logic hw_addr_pin_0,
  input wire logic hw_addr_pin_1,
  input wire logic hw_addr_pin_2,
  input wire logic osc_source_select,
  // Oscillator pin drive.
  output logic osc_out,
  output logic osc_oe_n,
  // Analog front end control.
  input wire logic comp_in,
  output logic aout_enable,
  output logic track_hold,
  output logic [1:0] sample_chan,
  output logic sample_diff,
  output logic [7:0] sar_code
);

  typedef struct packed {
    bus_state_t st;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [2:0] addr_s1;
    logic [2:0] addr_s2;
    logic ext_s1;
    logic ext_s2;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [7:0] ctrl;
    logic [7:0] hold;
    logic rw;
    logic mack;
    logic sda_o;
    logic sda_oe_n;
    logic [1:0] byte_idx;
    logic busy;
    logic req_tgl;
    logic [1:0] conv_ch;
    logic conv_diff;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic [11:0] wake;
    logic osc_rst;
    logic [7:0] div;
    logic osc_o;
    logic osc_oe_n;
  } mstate_t;

  typedef struct packed {
    conv_state_t st;
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic comp_s1;
    logic comp_s2;
    logic [7:0] code;
    logic [7:0] res;
    logic [2:0] bitn;
    logic [1:0] cnt;
    logic track;
    logic [1:0] chan;
    logic diff;
    logic ack_tgl;
  } ostate_t;

  mstate_t mq;
  mstate_t md;
  ostate_t oq;
  ostate_t od;
  logic rise_ev;
  logic fall_ev;
  logic start_ev;
  logic stop_ev;
  logic done_ev;
  logic do_launch;
  logic addr_match;
  logic [1:0] mode;

  // Bus events come from the second and third sync stages only.
  assign rise_ev = mq.scl_s2 && !mq.scl_s3;
  assign fall_ev = !mq.scl_s2 && mq.scl_s3;
  assign start_ev = mq.scl_s2 && mq.scl_s3 && mq.sda_s3 && !mq.sda_s2;
  assign stop_ev = mq.scl_s2 && mq.scl_s3 && !mq.sda_s3 && mq.sda_s2;
  assign done_ev = mq.ack_s2 ^ mq.ack_s3;
  assign addr_match = (mq.shreg[7:1] == {ADDR_FIXED, mq.addr_s2});
  assign mode = mq.ctrl[CTRL_MODE_LSB +: 2];

  // Bus slave, control setting and oscillator divider on the main clock.
  always_comb
  begin
    md = mq;
    do_launch = 1'b0;
    md.scl_s1 = scl_in;
    md.scl_s2 = mq.scl_s1;
    md.scl_s3 = mq.scl_s2;
    md.sda_s1 = sda_in;
    md.sda_s2 = mq.sda_s1;
    md.sda_s3 = mq.sda_s2;
    md.addr_s1 = {hw_addr_pin_2, hw_addr_pin_1, hw_addr_pin_0};
    md.addr_s2 = mq.addr_s1;
    md.ext_s1 = osc_source_select;
    md.ext_s2 = mq.ext_s1;
    md.ack_s1 = oq.ack_tgl;
    md.ack_s2 = mq.ack_s1;
    md.ack_s3 = mq.ack_s2;
    // Bits are sampled on the clock rise, so a change while high is never data.
    if (rise_ev && (mq.st == S_ADDR || mq.st == S_WR_BYTE))
    begin
      md.shreg = {mq.shreg[6:0], mq.sda_s2};
      md.bitcnt = mq.bitcnt + 4'h1;
    end
    case (mq.st)
      S_ADDR:
      begin
        if (fall_ev && mq.bitcnt == 4'h8)
        begin
          if (addr_match)
          begin
            md.rw = mq.shreg[0];
            md.st = S_ADDR_ACK;
            md.sda_oe_n = 1'b0;
          end
          else
          begin
            md.st = S_IDLE;
          end
        end
      end
      S_ADDR_ACK:
      begin
        if (fall_ev)
        begin
          md.bitcnt = 4'h0;
          if (mq.rw)
          begin
            do_launch = 1'b1;
            md.st = S_RD_BYTE;
          end
          else
          begin
            md.sda_oe_n = 1'b1;
            md.byte_idx = 2'h0;
            md.st = S_WR_BYTE;
          end
        end
      end
      S_WR_BYTE:
      begin
        if (fall_ev && mq.bitcnt == 4'h8)
        begin
          md.st = S_WR_ACK;
          md.sda_oe_n = 1'b0;
        end
      end
      S_WR_ACK:
      begin
        // Later write bytes are acknowledged but carry nothing for this block.
        if (fall_ev)
        begin
          md.sda_oe_n = 1'b1;
          md.bitcnt = 4'h0;
          md.byte_idx = (mq.byte_idx == 2'h3) ? mq.byte_idx : mq.byte_idx + 2'h1;
          md.st = S_WR_BYTE;
        end
      end
      S_RD_BYTE:
      begin
        if (rise_ev)
        begin
          md.bitcnt = mq.bitcnt + 4'h1;
        end
        if (fall_ev && mq.bitcnt == 4'h8)
        begin
          md.sda_oe_n = 1'b1;
          md.st = S_RD_ACK;
        end
        else if (fall_ev)
        begin
          md.tx = {mq.tx[6:0], 1'b0};
          md.sda_oe_n = mq.tx[6];
        end
      end
      S_RD_ACK:
      begin
        if (rise_ev)
        begin
          md.mack = !mq.sda_s2;
        end
        if (fall_ev && mq.mack)
        begin
          md.bitcnt = 4'h0;
          do_launch = 1'b1;
          md.st = S_RD_BYTE;
        end
        else if (fall_ev)
        begin
          md.sda_oe_n = 1'b1;
          md.st = S_IDLE;
        end
      end
      default:
      begin
        md.st = S_IDLE;
      end
    endcase
    // A launch loads the previous result for sending and, unless one is still running, starts the next one.
    if (do_launch)
    begin
      md.tx = mq.hold;
      md.sda_oe_n = mq.hold[7];
      if (!mq.busy)
      begin
        md.busy = 1'b1;
        md.conv_ch = chan_eff(mode, mq.ctrl[1:0]);
        md.conv_diff = chan_is_diff(mode, mq.ctrl[1:0]);
        md.req_tgl = !mq.req_tgl;
      end
    end
    // The result word is stable long before its toggle arrives here.
    if (done_ev)
    begin
      md.hold = oq.res;
      md.busy = 1'b0;
      if (mq.ctrl[CTRL_AINC_BIT])
      begin
        md.ctrl[1:0] = chan_next(mode, mq.ctrl[1:0]);
      end
    end
    // A control write in the same cycle overrides the auto-increment.
    if (mq.st == S_WR_BYTE && fall_ev && mq.bitcnt == 4'h8 && mq.byte_idx == 2'h0)
    begin
      md.ctrl = mq.shreg;
    end
    // Start and stop win over every bus state.
    if (start_ev)
    begin
      md.st = S_ADDR;
      md.bitcnt = 4'h0;
      md.sda_oe_n = 1'b1;
    end
    else if (stop_ev)
    begin
      md.st = S_IDLE;
      md.sda_oe_n = 1'b1;
    end
    // The wake window keeps the oscillator alive so its domain leaves reset cleanly.
    md.wake = (mq.wake == 12'h000) ? mq.wake : mq.wake - 12'h001;
    md.osc_rst = (mq.wake > OSC_WAKE_TAIL);
    md.osc_oe_n = mq.ext_s2;
    if (!mq.ext_s2 && (mq.wake != 12'h000 || mq.busy || mq.ctrl[CTRL_AOUT_BIT]))
    begin
      md.div = (mq.div == OSC_HALF_CYC - 8'h01) ? 8'h00 : mq.div + 8'h01;
      md.osc_o = (mq.div == OSC_HALF_CYC - 8'h01) ? !mq.osc_o : mq.osc_o;
    end
    else
    begin
      md.div = 8'h00;
      md.osc_o = 1'b0;
    end
    if (srst)
    begin
      md = '0;
      md.hold = RESULT_RST;
      md.ctrl = CTRL_RST;
      md.sda_oe_n = 1'b1;
      md.osc_oe_n = 1'b1;
      md.wake = OSC_WAKE_CYC;
      md.osc_rst = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    mq <= md;
  end

  // Conversion engine on the oscillator clock; its reset comes through a synchroniser.
  always_comb
  begin
    od = oq;
    od.rst_s1 = mq.osc_rst;
    od.rst_s2 = oq.rst_s1;
    od.req_s1 = mq.req_tgl;
    od.req_s2 = oq.req_s1;
    od.req_s3 = oq.req_s2;
    od.comp_s1 = comp_in;
    od.comp_s2 = oq.comp_s1;
    case (oq.st)
      C_IDLE:
      begin
        if (oq.req_s2 ^ oq.req_s3)
        begin
          od.track = 1'b1;
          od.chan = mq.conv_ch;
          od.diff = mq.conv_diff;
          od.st = C_SAMPLE;
        end
      end
      C_SAMPLE:
      begin
        od.track = 1'b0;
        od.code = 8'h80;
        od.bitn = 3'h7;
        od.cnt = 2'h0;
        od.st = C_TRIAL;
      end
      C_TRIAL:
      begin
        od.cnt = oq.cnt + 2'h1;
        if (oq.cnt == SAR_SETTLE)
        begin
          od.code[oq.bitn] = oq.comp_s2;
          if (oq.bitn == 3'h0)
          begin
            od.st = C_DONE;
          end
          else
          begin
            od.bitn = oq.bitn - 3'h1;
            od.code[oq.bitn - 3'h1] = 1'b1;
          end
        end
      end
      C_DONE:
      begin
        // Offset binary becomes two's complement by inverting the top bit.
        od.res = oq.diff ? {!oq.code[7], oq.code[6:0]} : oq.code;
        od.ack_tgl = !oq.ack_tgl;
        od.st = C_IDLE;
      end
      default:
      begin
        od.st = C_IDLE;
      end
    endcase
    if (oq.rst_s2)
    begin
      od = '0;
      od.rst_s1 = mq.osc_rst;
      od.rst_s2 = oq.rst_s1;
    end
  end

  always_ff @(posedge osc_clk)
  begin
    oq <= od;
  end

  // Outputs straight from the state flip-flops.
  assign sda_out = mq.sda_o;
  assign sda_oe_n = mq.sda_oe_n;
  assign osc_out = mq.osc_o;
  assign osc_oe_n = mq.osc_oe_n;
  assign aout_enable = mq.ctrl[CTRL_AOUT_BIT];
  assign track_hold = oq.track;
  assign sample_chan = oq.chan;
  assign sample_diff = oq.diff;
  assign sar_code = oq.code;

  // Checks on the main clock.
  chk_ack_drive: assert property (@(posedge mclk) disable iff (srst)
    ((mq.st == S_ADDR_ACK || mq.st == S_WR_ACK) && mq.scl_s2) |-> !mq.sda_oe_n)
    else $error("acknowledge not driven low during clock high");
  chk_nack_release: assert property (@(posedge mclk) disable iff (srst)
    (mq.st == S_RD_ACK && fall_ev && !mq.mack && !start_ev && !stop_ev) |=> (mq.st == S_IDLE && mq.sda_oe_n))
    else $error("data not released after missing acknowledge");
  chk_start_frame: assert property (@(posedge mclk) disable iff (srst)
    start_ev |=> (mq.st == S_ADDR && mq.bitcnt == 4'h0 && mq.sda_oe_n))
    else $error("start did not open an address phase");
  chk_stop_idle: assert property (@(posedge mclk) disable iff (srst)
    (stop_ev && !start_ev) |=> (mq.st == S_IDLE) ##1 (mq.sda_oe_n))
    else $error("stop did not return to idle");
  chk_addr_ignore: assert property (@(posedge mclk) disable iff (srst)
    (mq.st == S_ADDR && fall_ev && mq.bitcnt == 4'h8 && !addr_match && !start_ev && !stop_ev)
      |=> (mq.st == S_IDLE && mq.sda_oe_n))
    else $error("foreign address was acknowledged");
  chk_read_launch: assert property (@(posedge mclk) disable iff (srst)
    (mq.st == S_ADDR_ACK && mq.rw && fall_ev && !mq.busy && !start_ev && !stop_ev)
      |=> (mq.req_tgl != $past(mq.req_tgl) && mq.busy))
    else $error("read address did not launch a conversion");
  chk_launch_edge: assert property (@(posedge mclk) disable iff (srst)
    $changed(mq.req_tgl) |-> $past(fall_ev))
    else $error("conversion launched away from a clock fall");
  chk_first_byte: assert property (@(posedge mclk) disable iff (srst)
    (do_launch && !start_ev && !stop_ev) |=> (mq.tx == $past(mq.hold) && mq.sda_oe_n == mq.tx[7]))
    else $error("sent byte is not the held result");
  chk_reset_values: assert property (@(posedge mclk)
    $fell(srst) |-> (mq.hold == RESULT_RST && mq.ctrl == CTRL_RST))
    else $error("reset values of result or control wrong");
  chk_ctrl_store: assert property (@(posedge mclk) disable iff (srst)
    (mq.st == S_WR_BYTE && fall_ev && mq.bitcnt == 4'h8 && mq.byte_idx == 2'h0 && !start_ev && !stop_ev)
      |=> (mq.ctrl == $past(mq.shreg)))
    else $error("control byte not stored");
  chk_auto_inc: assert property (@(posedge mclk) disable iff (srst)
    (done_ev && mq.ctrl[CTRL_AINC_BIT] && !(mq.st == S_WR_BYTE && fall_ev))
      |=> (mq.ctrl[1:0] == chan_next($past(mode), $past(mq.ctrl[1:0])) && mq.hold == $past(oq.res)))
    else $error("channel not advanced after conversion");
  chk_osc_pin: assert property (@(posedge mclk) disable iff (srst)
    mq.ext_s2 |=> (mq.osc_oe_n ##1 (!mq.osc_o)))
    else $error("oscillator pin driven under external clock");

  // Checks on the oscillator clock.
  chk_conv_length: assert property (@(posedge osc_clk) disable iff (oq.rst_s2)
    (oq.st == C_SAMPLE) |-> ##33 (oq.st == C_DONE))
    else $error("conversion did not take thirty-three cycles");
  chk_diff_code: assert property (@(posedge osc_clk) disable iff (oq.rst_s2)
    (oq.st == C_DONE) |=> (oq.res[7] == ($past(oq.diff) ^ $past(oq.code[7])) && oq.res[6:0] == $past(oq.code[6:0])))
    else $error("result coding wrong");

  // Main scenarios.
  cov_read_launch: cover property (@(posedge mclk) disable iff (srst)
    (mq.st == S_ADDR_ACK && mq.rw && fall_ev) ##[1:1000] done_ev);
  cov_ctrl_write: cover property (@(posedge mclk) disable iff (srst)
    (mq.st == S_WR_ACK && mq.byte_idx == 2'h0) ##[1:1000] stop_ev);
  cov_read_nack: cover property (@(posedge mclk) disable iff (srst)
    (mq.st == S_RD_ACK && fall_ev && !mq.mack) ##[1:1000] stop_ev);
  cov_diff_conv: cover property (@(posedge osc_clk) disable iff (oq.rst_s2)
    (oq.st == C_DONE && oq.diff));

endmodule
`default_nettype wire

// ---- adc_slave_pkg.sv ----
// Shared constants, types and decode functions of the serial converter readout slave.
`default_nettype none
package adc_slave_pkg;

  // Reset values.
  localparam logic [7:0] RESULT_RST = 8'h80;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Control setting field positions.
  localparam int CTRL_AOUT_BIT = 6;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_AINC_BIT = 2;

  // Upper part of the slave address; the value is arbitrary.
  localparam logic [3:0] ADDR_FIXED = 4'h4;

  // Internal oscillator timing.
  localparam int MCLK_KHZ = 125000;
  localparam int OSC_KHZ = 1000;
  localparam logic [7:0] OSC_HALF_CYC = 8'(MCLK_KHZ / (2 * OSC_KHZ));
  localparam logic [11:0] OSC_WAKE_CYC = 12'hfff;
  localparam logic [11:0] OSC_WAKE_TAIL = 12'h800;

  // Converter timing in oscillator cycles per decided bit, less one.
  localparam logic [1:0] SAR_SETTLE = 2'h3;

  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_WR_BYTE, S_WR_ACK, S_RD_BYTE, S_RD_ACK} bus_state_t;
  typedef enum {C_IDLE, C_SAMPLE, C_TRIAL, C_DONE} conv_state_t;

  // Highest channel that exists for an input configuration.
  function automatic logic [1:0] chan_max(input logic [1:0] mode);
    case (mode)
      2'h0: chan_max = 2'h3;
      2'h3: chan_max = 2'h1;
      default: chan_max = 2'h2;
    endcase
  endfunction

  // Channel really used: a missing channel maps to the highest one.
  function automatic logic [1:0] chan_eff(input logic [1:0] mode, input logic [1:0] ch);
    chan_eff = (ch > chan_max(mode)) ? chan_max(mode) : ch;
  endfunction

  // Channel that follows after an auto-increment, wrapping to zero.
  function automatic logic [1:0] chan_next(input logic [1:0] mode, input logic [1:0] ch);
    chan_next = (chan_eff(mode, ch) == chan_max(mode)) ? 2'h0 : chan_eff(mode, ch) + 2'h1;
  endfunction

  // True when the channel is a differential pair.
  function automatic logic chan_is_diff(input logic [1:0] mode, input logic [1:0] ch);
    case (mode)
      2'h1: chan_is_diff = 1'b1;
      2'h2: chan_is_diff = (chan_eff(mode, ch) == 2'h2);
      2'h3: chan_is_diff = 1'b1;
      default: chan_is_diff = 1'b0;
    endcase
  endfunction

endpackage
`default_nettype wire

// ---- bus_master_model.sv ----
// Behavioural two-wire bus master that bit-bangs transfers for the bench.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model #(
  parameter int Q = 14
) (
  // Pacing clock.
  input wire logic mclk,
  // Bus lines.
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Both lines rest high until a transfer begins.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Quarter bit; lines only move at falling edges so the slave never races them.
  task automatic qw();
    repeat (Q) @(negedge mclk);
  endtask

  // Data falls while the clock is high; from a low clock it is a repeated start.
  task automatic start();
    qw();
    sda_pull = 1'b0;
    qw();
    scl = 1'b1;
    qw();
    sda_pull = 1'b1;
    qw();
    scl = 1'b0;
  endtask

  // Data rises while the clock is high, leaving the bus idle.
  task automatic stop();
    qw();
    sda_pull = 1'b1;
    qw();
    scl = 1'b1;
    qw();
    sda_pull = 1'b0;
    qw();
  endtask

  // One clock pulse per bit; data is held through the whole high phase.
  task automatic bit_io(input logic b, output logic r);
    qw();
    sda_pull = !b;
    qw();
    scl = 1'b1;
    qw();
    r = sda;
    qw();
    scl = 1'b0;
  endtask

  // Sends a byte MSB first and reports whether the ninth bit was pulled low.
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Takes a byte MSB first; the last byte wanted is left unacknowledged.
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

// ---- serial_adc_readout_slave_tb.sv ----
// Self-checking bench for the converter readout slave driven by a bus master model.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_readout_slave_tb;
  import adc_slave_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  logic mclk, srst, ext_clk, osc_clk, scl, sda_pull, sda, sda_out, sda_oe_n;
  logic osc_source_select, osc_out, osc_oe_n, comp_in, aout_enable, track_hold, sample_diff;
  logic [1:0] sample_chan, cur_ch, cur_mode;
  logic [7:0] sar_code, hold_e, nxt;
  logic [7:0] ana [4] = '{8'h3c, 8'ha5, 8'h5a, 8'hc3};
  logic [7:0] modes [3] = '{8'h17, 8'h26, 8'h33};
  logic cur_ainc, ack, prev;
  int tog;
  logic [1:0] exp_ch, seen_ch;
  logic exp_df, seen_df;
  int n_launch = 0;
  int n_track = 0;
  int n_mismatch = 0;
  int total_checks = 0;

  // Main clock.
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end

  // External conversion clock, running from time zero and unrelated in phase.
  initial
  begin
    ext_clk = 1'b0;
    #13;
    forever #40 ext_clk = !ext_clk;
  end

  // Open-drain data line with pull-up, shared oscillator pin, and comparator model.
  assign sda = ((sda_oe_n === 1'b0) ? sda_out : 1'b1) & !sda_pull;
  assign osc_clk = (osc_oe_n === 1'b0) ? osc_out : ext_clk;
  assign comp_in = (ana[sample_chan] >= sar_code) === 1'b1;

  adc_readout_slave i_dut (.mclk(mclk), .srst(srst), .osc_clk(osc_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hw_addr_pin_0(PINS[0]), .hw_addr_pin_1(PINS[1]),
    .hw_addr_pin_2(PINS[2]), .osc_source_select(osc_source_select), .osc_out(osc_out),
    .osc_oe_n(osc_oe_n), .comp_in(comp_in), .aout_enable(aout_enable), .track_hold(track_hold),
    .sample_chan(sample_chan), .sample_diff(sample_diff), .sar_code(sar_code));
  bus_master_model i_master (.mclk(mclk), .scl(scl), .sda_pull(sda_pull), .sda(sda));

  // Records every sample the converter takes, so channel, coding and count can be checked.
  always @(posedge osc_clk)
  begin
    if (track_hold === 1'b1)
    begin
      seen_ch <= sample_chan;
      seen_df <= sample_diff;
      n_track <= n_track + 1;
    end
  end

  // Compares a seen value with the expected one and logs any difference.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Expected result of one launch; the channel advances as the setting asks.
  function automatic logic [7:0] conv();
    logic [1:0] mx;
    logic [1:0] ch;
    logic df;
    mx = (cur_mode == 2'h0) ? 2'h3 : (cur_mode == 2'h3) ? 2'h1 : 2'h2;
    ch = (cur_ch > mx) ? mx : cur_ch;
    df = cur_mode[0] || (cur_mode == 2'h2 && ch == 2'h2);
    exp_ch = ch;
    exp_df = df;
    n_launch++;
    if (cur_ainc)
      cur_ch = (ch == mx) ? 2'h0 : ch + 2'h1;
    return df ? ana[ch] ^ 8'h80 : ana[ch];
  endfunction

  // Write transfer: address, control setting, one spare byte, then stop.
  task automatic write_ctrl(input logic [7:0] c);
    i_master.start();
    i_master.send({ADDR_FIXED, PINS, 1'b0}, ack);
    chk("write address ack", 8'(ack), 8'h01);
    i_master.send(c, ack);
    chk("control ack", 8'(ack), 8'h01);
    i_master.send(8'h00, ack);
    chk("spare byte ack", 8'(ack), 8'h01);
    i_master.stop();
    {cur_mode, cur_ainc, cur_ch} = {c[5:4], c[2], c[1:0]};
  endtask

  // Read of n bytes; the address and every acknowledged byte launch a conversion.
  task automatic read_n(input int n);
    logic [7:0] d;
    i_master.start();
    i_master.send({ADDR_FIXED, PINS, 1'b1}, ack);
    chk("read address ack", 8'(ack), 8'h01);
    nxt = conv();
    for (int k = 0; k < n; k++)
    begin
      i_master.recv(k < n - 1, d);
      chk("read byte", d, hold_e);
      chk("sample count", 8'(n_track), 8'(n_launch));
      chk("sample channel", {5'h00, seen_df, seen_ch}, {5'h00, exp_df, exp_ch});
      hold_e = nxt;
      if (k < n - 1)
        nxt = conv();
    end
    repeat (8) @(negedge mclk);
    chk("release after nack", 8'(sda_oe_n), 8'h01);
    i_master.stop();
  endtask

  // Reset, then the scenarios in order.
  initial
  begin
    srst = 1'b1;
    osc_source_select = 1'b1;
    hold_e = 8'h80;
    {cur_mode, cur_ainc, cur_ch} = '0;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    // The conversion domain needs its own reset to settle before the first read.
    repeat (4200) @(negedge mclk);
    chk("aout after reset", 8'(aout_enable), 8'h00);
    chk("osc pin released", 8'(osc_oe_n), 8'h01);
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      i_master.start();
      i_master.send({ADDR_FIXED ^ 4'(1 - i), PINS ^ 3'(2 * i), 1'b1}, ack);
      chk("foreign address ack", 8'(ack), 8'h00);
      i_master.stop();
    end
    $display("test foreign address done");
    read_n(2);
    $display("test first read done");
    write_ctrl(8'h44);
    chk("aout enable", 8'(aout_enable), 8'h01);
    read_n(6);
    $display("test auto increment done");
    foreach (modes[i])
    begin
      write_ctrl(modes[i]);
      read_n(3);
    end
    $display("test input modes done");
    write_ctrl(8'h40);
    osc_source_select = 1'b0;
    repeat (8) @(negedge mclk);
    chk("osc pin driven", 8'(osc_oe_n), 8'h00);
    tog = 0;
    prev = osc_out;
    repeat (300)
    begin
      @(negedge mclk);
      tog += (osc_out !== prev);
      prev = osc_out;
    end
    chk("osc running", 8'(tog > 1), 8'h01);
    osc_source_select = 1'b1;
    repeat (8) @(negedge mclk);
    chk("osc pin released", 8'(osc_oe_n), 8'h01);
    $display("test oscillator done");
    final_report();
  end

  // Cuts a hang short; the tests need about twenty-six thousand cycles.
  initial
  begin
    repeat (80000) @(posedge mclk);
    n_mismatch++;
    final_report();
  end
endmodule
`default_nettype wire
